// ==== icrd_pkg.sv ====
// package: constants and types for the ISA clock, recovery and decode config block
// ====================================================================
// Functional notes
// - recovery enable bit gates programmed 16-bit delay
// - codes 01/10/11/00 add 1/2/3/4 SYSCLKs
// - SYSCLK is PCICLK divided by 4 or 3
// - reset control bit holds RSTDRV asserted
// - mouse bit routes shared pin to mouse
// - coprocessor error raises IRQ13, gates ignore output
// - upper BIOS positive decode unless memory select bit4
// - upper BIOS always gives BIOS code, transceiver
// - disabled device gets no code, no transceiver, except upper BIOS
// - extended BIOS range decoded only when enabled
// - lower BIOS enabled: BIOS code, positive PCI decode
// - lower BIOS disabled: ISA forwarded when decode bit3
// - IDE enable decodes selected primary or secondary range
// - one select bit picks floppy and IDE range
// - floppy decode table, media change forces 111
// - shared IDE/floppy ports go to IDE when enabled
// - keyboard controller four ports gated by enable
// - real-time clock ports and strobes gated by enable
// - at least five SYSCLKs between ISA I/O cycles
// - no programmed delay between assembly sub-cycles
`default_nettype none
package icrd_pkg;
  // ====================================================================
  // register map: index, byte address is four times the index
  localparam int APB_AW = 12;
  localparam logic [7:0] IDX_RECOV = 8'h4C;
  localparam logic [7:0] IDX_CLKDIV = 8'h4D;
  localparam logic [7:0] IDX_CSA = 8'h4E;
  localparam logic [7:0] RST_RECOV = 8'h56;
  localparam logic [7:0] RST_CLKDIV = 8'h40;
  localparam logic [7:0] RST_CSA = 8'h07;
  localparam logic [7:0] WMASK_7BIT = 8'h7F;
  // ====================================================================
  // field positions
  localparam int REC_EN = 2;
  localparam int ICD_UBIOS = 6;
  localparam int ICD_COP = 5;
  localparam int ICD_MOUSE = 4;
  localparam int ICD_RSTDRV = 3;
  localparam int CSA_EXT = 7;
  localparam int CSA_LBIOS = 6;
  localparam int CSA_SEC = 5;
  localparam int CSA_IDE = 4;
  localparam int CSA_FLP_HI = 3;
  localparam int CSA_FLP_LO = 2;
  localparam int CSA_KBC = 1;
  localparam int CSA_RTC = 0;
  // ====================================================================
  // clock divisor and recovery counts
  localparam logic [2:0] DIV_CODE_3 = 3'h1;
  localparam logic [2:0] DIV_CODE_4 = 3'h0;
  localparam logic [1:0] DIV3_LAST = 2'h2;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [1:0] SYSCLK_HIGH = 2'h2;
  localparam logic [3:0] REC_MIN = 4'h5;
  localparam logic [3:0] REC_ADD_00 = 4'h4;
  // ====================================================================
  // encoded chip select codes
  localparam logic [2:0] CS_BIOS = 3'h0;
  localparam logic [2:0] CS_IDE0 = 3'h1;
  localparam logic [2:0] CS_IDE1 = 3'h2;
  localparam logic [2:0] CS_KBC = 3'h3;
  localparam logic [2:0] CS_FLOPPY = 3'h4;
  localparam logic [2:0] CS_RTC = 3'h5;
  localparam logic [2:0] CS_IDLE = 3'h6;
  localparam logic [2:0] CS_MEDIA = 3'h7;
  // ====================================================================
  // address windows
  localparam logic [15:0] SEG_UP = 16'h000F;
  localparam logic [15:0] SEG_UP_4G = 16'hFFFF;
  localparam logic [15:0] SEG_UP_4G1M = 16'hFFEF;
  localparam logic [15:0] SEG_LO = 16'h000E;
  localparam logic [15:0] SEG_LO_4G = 16'hFFFE;
  localparam logic [15:0] SEG_LO_4G1M = 16'hFFEE;
  localparam logic [31:0] EXT_LO = 32'hFFF80000;
  localparam logic [31:0] EXT_HI = 32'hFFFDFFFF;
  localparam logic [15:0] FLP_PRI = 16'h03F0;
  localparam logic [15:0] FLP_SEC = 16'h0370;
  localparam logic [15:0] IDE_PRI = 16'h01F0;
  localparam logic [15:0] IDE_SEC = 16'h0170;
  localparam logic [15:0] SHARED_OFS = 16'h0006;
  localparam logic [15:0] KBC_BASE = 16'h0060;
  localparam logic [15:0] RTC_BASE = 16'h0070;
  // synchroniser reset: {media_change, fpu_error, mouse_irq}
  localparam logic [2:0] SYNC_RST = 3'h4;
  // ====================================================================
  // types
  typedef struct packed {
    logic valid;
    logic is_io;
    logic from_pci;
    logic [31:0] addr;
  } icrd_req_s;
  typedef struct packed {
    logic valid;
    logic [2:0] cs;
    logic xcvr;
    logic floppy_n;
    logic rtc_ale_n;
    logic rtc_cs_n;
    logic positive;
    logic to_pci;
  } icrd_resp_s;
  localparam icrd_resp_s RESP_IDLE = '{1'b0, CS_IDLE, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  // total SYSCLKs of recovery after an I/O command
  function automatic logic [3:0] rec_total(input logic en, input logic [1:0] code, input logic sub);
    logic [3:0] add;
    add = (code == 2'h0) ? REC_ADD_00 : {2'h0, code};
    if (sub || !en) add = 4'h0;
    return REC_MIN + add;
  endfunction
  function automatic logic seg_any(input logic [15:0] s, input logic [15:0] a, input logic [15:0] b,
                                   input logic [15:0] c);
    return (s == a) || (s == b) || (s == c);
  endfunction
endpackage
`default_nettype wire

// ==== icrd_top.sv ====
// module: ISA clock divisor, I/O recovery timer and utility-bus chip-select decode
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module icrd_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [icrd_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire icrd_pkg::icrd_req_s dec_req,
  output icrd_pkg::icrd_resp_s dec_resp,
  input wire logic io_cycle_done,
  input wire logic io_cycle_16bit,
  input wire logic io_cycle_sub,
  output logic io_recovery_busy,
  output logic sysclk_out,
  input wire logic isa_reset_req,
  output logic rstdrv_out,
  input wire logic mouse_irq_pin,
  output logic irq12_out,
  output logic mouse_irq_out,
  input wire logic fpu_error_in,
  input wire logic fpu_ignore_req,
  output logic irq13_out,
  output logic fpu_ignore_out,
  input wire logic media_change_in,
  input wire logic main_mem_select_ctrl_bit4,
  input wire logic isa_decode_ctrl_bit3
);
  import icrd_pkg::*;

  // ====================================================================
  // pin synchronisers
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic mouse_s;
  logic fpu_s;
  logic media_s;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= SYNC_RST;
      pin_s2_q <= SYNC_RST;
    end else begin
      pin_s1_q <= {media_change_in, fpu_error_in, mouse_irq_pin};
      pin_s2_q <= pin_s1_q;
    end
  end
  assign mouse_s = pin_s2_q[0];
  assign fpu_s = pin_s2_q[1];
  assign media_s = pin_s2_q[2];

  // ====================================================================
  // APB slave: one setup cycle, then one access cycle with pready high
  logic [7:0] recov_q;
  logic [7:0] icd_q;
  logic [7:0] csa_q;
  logic [7:0] reg_idx;
  logic rd_hit;
  logic [7:0] rd_val;
  logic wr_go;

  assign reg_idx = paddr[9:2];

  always_comb begin
    rd_hit = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    rd_val = 8'h00;
    if (reg_idx == IDX_RECOV) begin
      rd_val = recov_q;
    end else if (reg_idx == IDX_CLKDIV) begin
      rd_val = icd_q;
    end else if (reg_idx == IDX_CSA) begin
      rd_val = csa_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // writes land only at the edge that completes the access phase
  assign wr_go = psel && penable && pready && pwrite && rd_hit;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= !rd_hit;
      prdata <= {24'h000000, rd_val};
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      recov_q <= RST_RECOV;
      icd_q <= RST_CLKDIV;
      csa_q <= RST_CSA;
    end else if (wr_go) begin
      if (reg_idx == IDX_RECOV) recov_q <= pwdata[7:0] & WMASK_7BIT;
      if (reg_idx == IDX_CLKDIV) icd_q <= pwdata[7:0] & WMASK_7BIT;
      if (reg_idx == IDX_CSA) csa_q <= pwdata[7:0];
    end
  end

  // ====================================================================
  // SYSCLK divider; reserved codes fall back to divide by four
  logic [1:0] div_q;
  logic [1:0] div_last;
  logic [1:0] div_d;
  logic sys_tick;

  assign div_last = (icd_q[2:0] == DIV_CODE_3) ? DIV3_LAST : DIV4_LAST;
  assign sys_tick = (div_q >= div_last);
  assign div_d = sys_tick ? 2'h0 : div_q + 2'h1;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // start at the end of a low phase so the first high phase is full length
      div_q <= DIV4_LAST;
      sysclk_out <= 1'b0;
    end else begin
      div_q <= div_d;
      sysclk_out <= (div_d < SYSCLK_HIGH);
    end
  end

  // ====================================================================
  // I/O recovery: counts SYSCLK ticks after the command ends, so the first period counted can be partial
  logic [3:0] rec_total_q;
  logic [3:0] rec_cnt_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rec_total_q <= REC_MIN;
      rec_cnt_q <= 4'h0;
      io_recovery_busy <= 1'b0;
    end else if (io_cycle_done) begin
      // 8-bit cycles only get the floor here; their own delay lives elsewhere
      rec_total_q <= rec_total(recov_q[REC_EN] && io_cycle_16bit, recov_q[1:0], io_cycle_sub);
      rec_cnt_q <= 4'h0;
      io_recovery_busy <= 1'b1;
    end else if (io_recovery_busy && sys_tick) begin
      rec_cnt_q <= rec_cnt_q + 4'h1;
      if (rec_cnt_q + 4'h1 >= rec_total_q) io_recovery_busy <= 1'b0;
    end
  end

  // ====================================================================
  // reset drive, mouse and coprocessor routing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstdrv_out <= 1'b0;
      irq12_out <= 1'b0;
      mouse_irq_out <= 1'b0;
      irq13_out <= 1'b0;
      fpu_ignore_out <= 1'b0;
    end else begin
      rstdrv_out <= icd_q[ICD_RSTDRV] || isa_reset_req;
      irq12_out <= !icd_q[ICD_MOUSE] && mouse_s;
      mouse_irq_out <= icd_q[ICD_MOUSE] && mouse_s;
      irq13_out <= fpu_s;
      fpu_ignore_out <= icd_q[ICD_COP] && fpu_s && fpu_ignore_req;
    end
  end

  // ====================================================================
  // address decode, answered one cycle after the request
  logic [15:0] seg;
  logic [15:0] io;
  logic [15:0] fbase;
  logic [15:0] ibase;
  logic up_hit;
  logic lo_hit;
  logic ext_hit;
  logic shared_hit;
  icrd_resp_s resp_d;

  assign seg = dec_req.addr[31:16];
  assign io = dec_req.addr[15:0];
  assign fbase = csa_q[CSA_SEC] ? FLP_SEC : FLP_PRI;
  assign ibase = csa_q[CSA_SEC] ? IDE_SEC : IDE_PRI;
  assign up_hit = seg_any(seg, SEG_UP, SEG_UP_4G, SEG_UP_4G1M);
  assign lo_hit = seg_any(seg, SEG_LO, SEG_LO_4G, SEG_LO_4G1M);
  assign ext_hit = (dec_req.addr >= EXT_LO) && (dec_req.addr <= EXT_HI);
  assign shared_hit = (io[15:1] == fbase[15:1] + SHARED_OFS[15:1]);

  always_comb begin
    resp_d = RESP_IDLE;
    if (dec_req.valid && !dec_req.is_io) begin
      if (up_hit) begin
        resp_d.cs = CS_BIOS;
        resp_d.xcvr = 1'b1;
        resp_d.positive = dec_req.from_pci && icd_q[ICD_UBIOS] && !main_mem_select_ctrl_bit4;
      end else if (lo_hit) begin
        if (csa_q[CSA_LBIOS]) begin
          resp_d.cs = CS_BIOS;
          resp_d.xcvr = 1'b1;
          resp_d.positive = dec_req.from_pci && !main_mem_select_ctrl_bit4;
        end else begin
          resp_d.to_pci = !dec_req.from_pci && isa_decode_ctrl_bit3;
        end
      end else if (ext_hit && dec_req.from_pci && csa_q[CSA_EXT]) begin
        resp_d.cs = CS_BIOS;
        resp_d.xcvr = 1'b1;
        resp_d.positive = 1'b1;
      end
    end else if (dec_req.valid) begin
      if (!media_s) begin
        resp_d.cs = CS_MEDIA;
      end else if (csa_q[CSA_IDE] && (shared_hit || io[15:3] == ibase[15:3])) begin
        resp_d.cs = shared_hit ? CS_IDE1 : CS_IDE0;
        resp_d.xcvr = 1'b1;
      end else if ((csa_q[CSA_FLP_HI] && io[15:1] == fbase[15:1]) ||
                   (csa_q[CSA_FLP_LO] && io[15:3] == fbase[15:3] && io[2:1] != 2'h0)) begin
        resp_d.cs = CS_FLOPPY;
        resp_d.floppy_n = 1'b0;
        resp_d.xcvr = 1'b1;
      end else if (csa_q[CSA_KBC] && io[15:3] == KBC_BASE[15:3] && !io[0]) begin
        resp_d.cs = CS_KBC;
        resp_d.xcvr = 1'b1;
      end else if (csa_q[CSA_RTC] && io[15:3] == RTC_BASE[15:3]) begin
        resp_d.cs = CS_RTC;
        resp_d.xcvr = 1'b1;
        resp_d.rtc_ale_n = io[0];
        resp_d.rtc_cs_n = !io[0];
      end
    end
    resp_d.valid = dec_req.valid;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dec_resp <= RESP_IDLE;
    end else begin
      dec_resp <= resp_d;
    end
  end

  // ====================================================================
  // assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_rstdrv_hold: assert property (icd_q[ICD_RSTDRV] |=> rstdrv_out)
    else $error("isa reset not driven while control bit set");
  a_recov_off: assert property ((io_cycle_done && !recov_q[REC_EN]) |=> (rec_total_q == REC_MIN && io_recovery_busy))
    else $error("disabled recovery added delay");
  a_recov_code00: assert property ((io_cycle_done && io_cycle_16bit && !io_cycle_sub && recov_q[REC_EN]
    && recov_q[1:0] == 2'h0) |=> rec_total_q == 4'h9)
    else $error("code 00 did not give nine sysclks");
  a_recov_sub: assert property ((io_cycle_done && io_cycle_sub) |=> rec_total_q == REC_MIN)
    else $error("sub-cycle got programmed delay");
  a_recov_floor: assert property ($fell(io_recovery_busy) |-> rec_cnt_q >= REC_MIN)
    else $error("recovery ended under five sysclks");
  a_sysclk_div4: assert property (($rose(sysclk_out) && icd_q[2:0] == DIV_CODE_4)
    |-> ##4 ($rose(sysclk_out) || icd_q[2:0] != DIV_CODE_4))
    else $error("sysclk period not four clocks");
  a_ubios_code: assert property ((dec_req.valid && !dec_req.is_io && up_hit)
    |=> (dec_resp.cs == CS_BIOS && dec_resp.xcvr))
    else $error("upper bios access without bios code");
  a_ubios_pos: assert property ((dec_req.valid && !dec_req.is_io && up_hit && !icd_q[ICD_UBIOS])
    |=> !dec_resp.positive)
    else $error("upper bios positively decoded while disabled");
  a_kbc_off: assert property ((dec_req.valid && dec_req.is_io && io == KBC_BASE && !csa_q[CSA_KBC])
    |=> (dec_resp.cs != CS_KBC && !dec_resp.xcvr))
    else $error("disabled keyboard controller decoded");
  a_media_force: assert property ((dec_req.valid && dec_req.is_io && !media_s)
    |=> (dec_resp.cs == CS_MEDIA && dec_resp.floppy_n))
    else $error("media change did not force code");
  a_ide_shared: assert property ((dec_req.valid && dec_req.is_io && media_s && csa_q[CSA_IDE] && shared_hit)
    |=> (dec_resp.cs == CS_IDE1 && dec_resp.floppy_n))
    else $error("shared port not routed to disk control");
  a_mouse_route: assert property ((icd_q[ICD_MOUSE] && mouse_s) |=> (mouse_irq_out && !irq12_out))
    else $error("mouse pin not routed to mouse");
  a_fpu_gate: assert property (fpu_ignore_out |-> $past(icd_q[ICD_COP]))
    else $error("ignore output with coprocessor support off");

  c_recov_done: cover property ($fell(io_recovery_busy));
  c_floppy_sel: cover property (!dec_resp.floppy_n);
  c_lbios_fwd: cover property (dec_resp.to_pci);
  c_rstdrv_sw: cover property (icd_q[ICD_RSTDRV] ##1 rstdrv_out);
endmodule // icrd_top
`default_nettype wire

// ==== icrd_isa_model.sv ====
// partner: ISA-side peripheral pins and a SYSCLK period meter
`timescale 1ns/1ns
`default_nettype none
module icrd_isa_model (
  input wire logic clk_sys,
  input wire logic link_clk,
  input wire logic sysclk_out,
  input wire logic mouse_lvl,
  input wire logic fpu_lvl,
  input wire logic media_lvl,
  output logic mouse_irq_pin,
  output logic fpu_error_in,
  output logic media_change_in,
  output logic [7:0] sys_period
);
  logic [7:0] cnt_q;
  logic sys_q;
  initial begin
    mouse_irq_pin = 1'b0;
    fpu_error_in = 1'b0;
    media_change_in = 1'b1;
    sys_period = 8'h00;
    cnt_q = 8'h00;
    sys_q = 1'b0;
  end
  // ====================================================================
  // pins move on the peripheral clock, so the core sees them truly async
  always @(posedge link_clk) begin
    mouse_irq_pin <= mouse_lvl;
    fpu_error_in <= fpu_lvl;
    media_change_in <= media_lvl;
  end
  // ====================================================================
  // core clocks between two SYSCLK rising edges
  always @(posedge clk_sys) begin
    sys_q <= sysclk_out;
    if (sysclk_out && !sys_q) begin
      sys_period <= cnt_q;
      cnt_q <= 8'h01;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule // icrd_isa_model
`default_nettype wire

// ==== isa_clock_recovery_decode_cfg_tb_top.sv ====
// testbench: register bus, decode model, recovery spans and ISA clock
`timescale 1ns/1ns
`default_nettype none
module isa_clock_recovery_decode_cfg_tb_top;
  import icrd_pkg::*;
  // ====================================================================
  // stimulus and observation signals
  logic clk_sys = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, io_recovery_busy, sysclk_out, rstdrv_out, irq12_out, mouse_irq_out;
  icrd_req_s dec_req = '0;
  icrd_resp_s dec_resp;
  logic io_cycle_done = 1'b0, io_cycle_16bit = 1'b0, io_cycle_sub = 1'b0, isa_reset_req = 1'b0;
  logic mouse_irq_pin, fpu_error_in, media_change_in, irq13_out, fpu_ignore_out;
  logic fpu_ignore_req = 1'b0, main_mem_select_ctrl_bit4 = 1'b0, isa_decode_ctrl_bit3 = 1'b0;
  logic mouse_lvl = 1'b0, fpu_lvl = 1'b0, media_lvl = 1'b1;
  logic [7:0] sys_period, csa;
  logic [31:0] rd, rng = 32'h00000058;
  logic er, ub, md = 1'b0;
  icrd_req_s q;
  icrd_resp_s ea [18];
  logic ia [18];
  int mismatches = 0, samples_checked = 0;
  int tot [4] = '{9, 6, 7, 8};
  logic [31:0] atab [30] = '{32'h1F0, 32'h1F7, 32'h170, 32'h177, 32'h3F0, 32'h3F1, 32'h3F2, 32'h3F6,
    32'h3F7, 32'h370, 32'h371, 32'h372, 32'h376, 32'h377, 32'h60, 32'h61, 32'h64, 32'h66, 32'h70,
    32'h75, 32'h100, 32'h000F8000, 32'hFFFF0010, 32'hFFEF0000, 32'h000E4000, 32'hFFFE0000,
    32'hFFEE0000, 32'hFFF80000, 32'hFFFDFFFF, 32'hFFF7FFFF};
  always #25 clk_sys = ~clk_sys;
  initial begin
    #7;
    forever #200 link_clk = ~link_clk;
  end
  icrd_top DUT (.clk_sys, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .dec_req, .dec_resp, .io_cycle_done, .io_cycle_16bit, .io_cycle_sub, .io_recovery_busy,
    .sysclk_out, .isa_reset_req, .rstdrv_out, .mouse_irq_pin, .irq12_out, .mouse_irq_out, .fpu_error_in,
    .fpu_ignore_req, .irq13_out, .fpu_ignore_out, .media_change_in, .main_mem_select_ctrl_bit4, .isa_decode_ctrl_bit3);
  icrd_isa_model far_side (.clk_sys, .link_clk, .sysclk_out, .mouse_lvl, .fpu_lvl, .media_lvl,
    .mouse_irq_pin, .fpu_error_in, .media_change_in, .sys_period);
  // ====================================================================
  // helpers
  function automatic logic [31:0] xrand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one APB transfer; waits for pready, never a fixed count
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rdat,
                     output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp, input logic experr);
    apb(1'b0, idx, 8'h00, rd, er);
    check(rd, {24'h000000, exp}, "read data");
    check(32'(er), 32'(experr), "slave error");
  endtask
  // recovery length in SYSCLK periods, rounded up from core clocks
  task automatic recov(input logic [7:0] rv, input logic b16, input logic sub, input int per, input int tn);
    int n;
    apb(1'b1, IDX_RECOV, rv, rd, er);
    io_cycle_done <= 1'b1;
    io_cycle_16bit <= b16;
    io_cycle_sub <= sub;
    @(posedge clk_sys);
    io_cycle_done <= 1'b0;
    n = 0;
    @(posedge clk_sys);
    while (io_recovery_busy === 1'b1 && n < 200) begin
      n++;
      @(posedge clk_sys);
    end
    check((n + per - 1) / per, tn, "recovery span");
  endtask
  // ====================================================================
  // reference decode model
  function automatic icrd_resp_s model(input icrd_req_s rq, input logic [7:0] c, input logic u);
    icrd_resp_s r;
    logic [15:0] a, s, fb, ib;
    r = RESP_IDLE;
    r.valid = 1'b1;
    a = rq.addr[15:0];
    s = rq.addr[31:16];
    fb = c[5] ? 16'h0370 : 16'h03F0;
    ib = c[5] ? 16'h0170 : 16'h01F0;
    if (!rq.is_io) begin
      if (s == 16'h000F || s == 16'hFFFF || s == 16'hFFEF) begin
        r.cs = CS_BIOS;
        r.positive = rq.from_pci & u & !main_mem_select_ctrl_bit4;
      end else if (s == 16'h000E || s == 16'hFFFE || s == 16'hFFEE) begin
        r.cs = c[6] ? CS_BIOS : CS_IDLE;
        r.positive = c[6] & rq.from_pci & !main_mem_select_ctrl_bit4;
        r.to_pci = !c[6] & !rq.from_pci & isa_decode_ctrl_bit3;
      end else if (c[7] && rq.from_pci && rq.addr >= 32'hFFF80000 && rq.addr <= 32'hFFFDFFFF) begin
        r.cs = CS_BIOS;
        r.positive = 1'b1;
      end
    end else if (md) r.cs = CS_MEDIA;
    else if (c[4] && a >= ib && a <= ib + 16'h0007) r.cs = CS_IDE0;
    else if (c[4] && (a == fb + 16'h0006 || a == fb + 16'h0007)) r.cs = CS_IDE1;
    else if (a >= fb && a <= fb + 16'h0007 && ((a - fb < 16'h0002) ? c[3] : c[2])) begin
      r.cs = CS_FLOPPY;
      r.floppy_n = 1'b0;
    end else if (c[1] && a[15:3] == 13'h000C && !a[0]) r.cs = CS_KBC;
    else if (c[0] && a[15:3] == 13'h000E) begin
      r.cs = CS_RTC;
      r.rtc_ale_n = a[0];
      r.rtc_cs_n = !a[0];
    end
    r.xcvr = (r.cs != CS_IDLE);
    return r;
  endfunction
  // positive decode is only judged on memory; media change judges code and floppy strobe only
  task automatic chk_resp(input icrd_resp_s s, input icrd_resp_s e, input logic io);
    logic [9:0] m;
    m = io ? (md ? 10'h3D0 : 10'h3FD) : 10'h3FF;
    check({22'h000000, s & m}, {22'h000000, e & m}, "decode answer");
  endtask
  // ====================================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk(IDX_RECOV, 8'h56, 1'b0);
    rchk(IDX_CLKDIV, 8'h40, 1'b0);
    rchk(IDX_CSA, 8'h07, 1'b0);
    rchk(8'h4F, 8'h00, 1'b1);
    apb(1'b1, IDX_RECOV, 8'hFF, rd, er);
    rchk(IDX_RECOV, 8'h7F, 1'b0);
    for (int c = 0; c < 8; c++) recov({5'h00, c[2:0]}, 1'b1, 1'b0, 4, c[2] ? tot[c[1:0]] : 5);
    recov(8'h05, 1'b1, 1'b1, 4, 5);
    recov(8'h05, 1'b0, 1'b0, 4, 5);
    // a 20 MHz core must divide by 3 to stay above 6 MHz; change it under ISA reset
    apb(1'b1, IDX_CLKDIV, 8'h49, rd, er);
    repeat (30) @(posedge clk_sys);
    check(32'(rstdrv_out), 32'h1, "reset drive on");
    apb(1'b1, IDX_CLKDIV, 8'h41, rd, er);
    repeat (20) @(posedge clk_sys);
    check(32'(rstdrv_out), 32'h0, "reset drive off");
    check(32'(sys_period), 32'h3, "divide by 3");
    recov(8'h06, 1'b1, 1'b0, 3, 7);
    isa_reset_req <= 1'b1;
    apb(1'b1, IDX_CLKDIV, 8'h45, rd, er);
    check(32'(rstdrv_out), 32'h1, "hardware reset drive");
    isa_reset_req <= 1'b0;
    repeat (20) @(posedge clk_sys);
    check(32'(sys_period), 32'h4, "reserved divisor");
    mouse_lvl <= 1'b1;
    fpu_lvl <= 1'b1;
    fpu_ignore_req <= 1'b1;
    for (int m = 1; m >= 0; m--) begin
      apb(1'b1, IDX_CLKDIV, m ? 8'h71 : 8'h41, rd, er);
      repeat (20) @(posedge clk_sys);
      check(32'(mouse_irq_out), 32'(m), "mouse route");
      check(32'(irq12_out), 32'(1 - m), "irq12 route");
      check(32'(fpu_ignore_out), 32'(m), "fpu ignore");
      check(32'(irq13_out), 32'h1, "irq13");
    end
    for (int b = 0; b < 30; b++) begin
      if (b == 27) begin
        media_lvl <= 1'b0;
        repeat (20) @(posedge clk_sys);
      end
      md = (b >= 27);
      csa = 8'(xrand());
      ub = rng[8];
      apb(1'b1, IDX_CSA, csa, rd, er);
      apb(1'b1, IDX_CLKDIV, {1'b0, ub, 6'h01}, rd, er);
      main_mem_select_ctrl_bit4 <= rng[9];
      isa_decode_ctrl_bit3 <= rng[10];
      for (int i = 0; i < 18; i++) begin
        @(posedge clk_sys);
        if (i >= 2) chk_resp(dec_resp, ea[i - 2], ia[i - 2]);
        q = '0;
        if (i < 16) begin
          q.addr = atab[xrand() % 30];
          q.valid = 1'b1;
          q.is_io = (q.addr[31:16] == 16'h0000);
          q.from_pci = rng[7];
          ea[i] = model(q, csa, ub);
          ia[i] = q.is_io;
        end
        dec_req <= q;
      end
    end
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    give_verdict();
  end
endmodule // isa_clock_recovery_decode_cfg_tb_top
`default_nettype wire
